// ---- sps_sequencer.sv ----
// setpoint program sequencer with register port and step memory
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sps_regs.svh"
// Behaviour
// - time unit h/m or m/s, reset only
// - start delay to 99h59m, lamp blinks
// - delay elapsed: run, lamp steady
// - hold on fault, drive error output
// - run on fault, drive error output
// - reset action abandons program on fault
// - power return default: reset state
// - continue restores program, clears auto tuning
// - advance by step or by time
// - time advance stops at step end
// - advance time zero disables time advance
// - end goes fixed, or reset if bound
// - channel one patterns 0..20, reinitialise
// - channel step pool patterns times twenty
// - step count changes only in reset
// - clip target to limits, flag it
// - step duration 00:00..99:59, default 00:01
// - set zero keeps previous step set
// - set zero at start uses one
// - start step zero marks pattern invalid
// - start target only from step one
// - lowered repeat count ends after pass
// - on-off output full at half or above
module sps_sequencer #(
	parameter int unsigned SEC_CYCLES = `SPS_SEC_CYC
) (
	input  wire logic               mclk_i,
	input  wire logic               rst_i,
	input  wire logic [7:0]         addr_i,
	input  wire logic [31:0]        wdata_i,
	input  wire logic               wr_i,
	input  wire logic               rd_i,
	output logic      [31:0]        rdata_o,
	input  wire logic               fault_i,
	input  wire logic               advance_i,
	input  wire logic               power_up_i,
	input  wire logic [9:0]         computed_out_i,
	output logic                    run_lamp_o,
	output logic signed [15:0]      target_value_o,
	output logic      [3:0]         pset_o,
	output logic      [9:0]         ctrl_out_o,
	output logic                    clipped_o,
	output logic                    fixed_o,
	output logic                    auto_tuning_o
);
	sps_pkg::sps_state_t q;
	sps_pkg::sps_state_t n;
	sps_pkg::sps_step_t  step_mem [0:`SPS_NSTEP_MAX-1];
	sps_pkg::sps_pat_t   pat_mem [0:`SPS_NPAT-1];
	sps_pkg::sps_pat_t   rp;
	sps_pkg::sps_pat_t   pat_wd;
	sps_pkg::sps_step_t  cs;
	sps_pkg::sps_step_t  step_wd;
	logic                pat_we;
	logic                step_we;
	logic                reinit;
	logic [8:0]          run_base;
	logic [9:0]          oth_sum;
	logic [8:0]          pool;
	logic [12:0]         dur_u;
	logic [12:0]         adv_u;
	logic [12:0]         dly_u;
	logic                adv_step;
	logic                adv_ev;
	logic                pwr_ev;
	logic                exec;
	logic                start_ok;
	logic signed [15:0]  raw_sv;
	logic [9:0]          out_v;

	sps_tick_if tk ();

	sps_timebase #(
		.SEC_CYCLES(SEC_CYCLES)
	) u_tb (
		.mclk_i(mclk_i),
		.rst_i (rst_i),
		.tk    (tk)
	);

	assign tk.unit_ms = q.unit_ms;

	function automatic logic [12:0] to_units(input logic [6:0] hi, input logic [5:0] lo);
		to_units = 13'(hi) * `SPS_MIN_PER_HR + 13'(lo);
	endfunction

	function automatic logic [6:0] sat_hi(input logic [6:0] v);
		sat_hi = (v > `SPS_HI_MAX) ? `SPS_HI_MAX : v;
	endfunction

	function automatic logic [5:0] sat_lo(input logic [5:0] v);
		sat_lo = (v > `SPS_LO_MAX) ? `SPS_LO_MAX : v;
	endfunction

	// ****************************************
	// pattern layout and current step
	// ****************************************
	always_comb begin
		run_base = '0;
		oth_sum  = '0;
		for (int i = 0; i < `SPS_NPAT; i++) begin
			if ((5'(i) < q.pat) && ((5'(i) < q.ch1cnt) == (q.pat < q.ch1cnt))) begin
				run_base = run_base + pat_mem[i].nsteps;
			end
			if ((5'(i) != q.psel) && ((5'(i) < q.ch1cnt) == (q.psel < q.ch1cnt))) begin
				oth_sum = oth_sum + 10'(pat_mem[i].nsteps);
			end
		end
		if (q.pat >= q.ch1cnt) begin
			run_base = run_base + 9'(q.ch1cnt) * `SPS_STEPS_PER_PAT;
		end
		if (q.psel < q.ch1cnt) begin
			pool = 9'(q.ch1cnt) * `SPS_STEPS_PER_PAT;
		end else begin
			pool = 9'(`SPS_NPAT_W - q.ch1cnt) * `SPS_STEPS_PER_PAT;
		end
		rp = pat_mem[q.pat];
		cs = step_mem[9'(run_base + q.cur)];
	end

	// ****************************************
	// sequencer and register port
	// ****************************************
	always_comb begin
		n = q;
		pat_we = 1'b0;
		step_we = 1'b0;
		reinit = 1'b0;
		adv_step = 1'b0;
		pat_wd = pat_mem[q.psel];
		step_wd = step_mem[q.ssel];
		n.rdata = '0;
		n.flt1 = fault_i;
		n.flt2 = q.flt1;
		n.adv1 = advance_i;
		n.adv2 = q.adv1;
		n.adv3 = q.adv2;
		n.pwr1 = power_up_i;
		n.pwr2 = q.pwr1;
		n.pwr3 = q.pwr2;
		adv_ev = q.adv2 & ~q.adv3;
		pwr_ev = q.pwr2 & ~q.pwr3;
		exec = (q.st == sps_pkg::S_RUN) || (q.st == sps_pkg::S_HOLD);
		start_ok = (rp.start != 9'h000) && (rp.start <= rp.nsteps);
		dur_u = to_units(cs.thi, cs.tlo);
		adv_u = to_units(q.adv_hi, q.adv_lo);
		dly_u = to_units(q.dly_hi, q.dly_lo);

		if (wr_i) begin
			case (addr_i)
				`SPS_A_CTRL: begin
					if (wdata_i[`SPS_CTRL_AT]) begin
						n.at = 1'b1;
					end
				end
				`SPS_A_CFG: begin
					// unit change accepted in reset only
					if (q.st == sps_pkg::S_RESET) begin
						n.unit_ms = wdata_i[`SPS_CFG_UNIT];
						if (wdata_i[`SPS_CFG_PAT] < `SPS_NPAT_W) begin
							n.pat = wdata_i[`SPS_CFG_PAT];
						end
					end
					n.err_act = sps_pkg::sps_err_t'(wdata_i[`SPS_CFG_ERR]);
					n.recov = wdata_i[`SPS_CFG_RECOV];
					n.advm = wdata_i[`SPS_CFG_ADVM];
					n.endfix = wdata_i[`SPS_CFG_ENDFIX];
					n.extfix = wdata_i[`SPS_CFG_EXTFIX];
					n.onoff = wdata_i[`SPS_CFG_ONOFF];
				end
				`SPS_A_DELAY: begin
					n.dly_hi = sat_hi(wdata_i[`SPS_T_HI]);
					n.dly_lo = sat_lo(wdata_i[`SPS_T_LO]);
				end
				`SPS_A_ADVT: begin
					n.adv_hi = sat_hi(wdata_i[`SPS_T_HI]);
					n.adv_lo = sat_lo(wdata_i[`SPS_T_LO]);
				end
				`SPS_A_ERROUT: begin
					n.err_out = (wdata_i[9:0] > `SPS_PCT_FULL) ? `SPS_PCT_FULL : wdata_i[9:0];
				end
				`SPS_A_LIMIT: begin
					n.lim_lo = wdata_i[15:0];
					n.lim_hi = wdata_i[31:16];
				end
				`SPS_A_CH1CNT: begin
					if ((q.st == sps_pkg::S_RESET) && (wdata_i[4:0] <= `SPS_NPAT_W)
						&& (wdata_i[4:0] != q.ch1cnt)) begin
						n.ch1cnt = wdata_i[4:0];
						n.pat = '0;
						reinit = 1'b1;
					end
				end
				`SPS_A_PSEL: begin
					n.psel = (wdata_i[4:0] < `SPS_NPAT_W) ? wdata_i[4:0] : q.psel;
				end
				`SPS_A_PDATA: begin
					pat_we = 1'b1;
					// step count fixed outside reset; pool bound
					if ((q.st == sps_pkg::S_RESET)
						&& ((oth_sum + 10'(wdata_i[`SPS_P_NSTEP])) <= 10'(pool))) begin
						pat_wd.nsteps = wdata_i[`SPS_P_NSTEP];
					end
					if (wdata_i[`SPS_P_START] <= pat_wd.nsteps) begin
						pat_wd.start = wdata_i[`SPS_P_START];
					end
					if ((wdata_i[`SPS_P_REPS] != 14'h0000) && (wdata_i[`SPS_P_REPS] <= `SPS_REP_MAX)) begin
						pat_wd.reps = wdata_i[`SPS_P_REPS];
					end
				end
				`SPS_A_PSV: begin
					pat_we = 1'b1;
					pat_wd.ssv = wdata_i[15:0];
				end
				`SPS_A_SSEL: begin
					if (wdata_i[8:0] < 9'(`SPS_NSTEP_MAX)) begin
						n.ssel = wdata_i[8:0];
					end
				end
				`SPS_A_SSV: begin
					step_we = 1'b1;
					step_wd.sv = wdata_i[15:0];
				end
				`SPS_A_STIME: begin
					step_we = 1'b1;
					step_wd.thi = sat_hi(wdata_i[`SPS_T_HI]);
					step_wd.tlo = sat_lo(wdata_i[`SPS_T_LO]);
					if (wdata_i[`SPS_T_PSET] <= `SPS_PSET_MAX) begin
						step_wd.pset = wdata_i[`SPS_T_PSET];
					end
				end
				default: begin
				end
			endcase
		end

		if (rd_i) begin
			case (addr_i)
				`SPS_A_CTRL:   n.rdata = {21'h0, q.at, q.clip, q.lamp, start_ok, 2'h0, q.st};
				`SPS_A_CFG:    n.rdata = {19'h0, q.pat, q.onoff, q.extfix, q.endfix, q.advm,
								q.recov, q.err_act, q.unit_ms};
				`SPS_A_DELAY:  n.rdata = {18'h0, q.dly_lo, 1'b0, q.dly_hi};
				`SPS_A_ADVT:   n.rdata = {18'h0, q.adv_lo, 1'b0, q.adv_hi};
				`SPS_A_ERROUT: n.rdata = {22'h0, q.err_out};
				`SPS_A_LIMIT:  n.rdata = {q.lim_hi, q.lim_lo};
				`SPS_A_CH1CNT: n.rdata = {27'h0, q.ch1cnt};
				`SPS_A_PSEL:   n.rdata = {27'h0, q.psel};
				`SPS_A_PDATA:  n.rdata = {pat_wd.reps, pat_wd.start, pat_wd.nsteps};
				`SPS_A_PSV:    n.rdata = {16'h0, pat_wd.ssv};
				`SPS_A_SSEL:   n.rdata = {23'h0, q.ssel};
				`SPS_A_SSV:    n.rdata = {16'h0, step_wd.sv};
				`SPS_A_STIME:  n.rdata = {12'h0, step_wd.pset, 2'h0, step_wd.tlo, 1'b0, step_wd.thi};
				`SPS_A_RUN:    n.rdata = {q.rep, q.cur, q.pset, q.elapsed[4:0]};
				default:       n.rdata = '0;
			endcase
		end

		case (q.st)
			sps_pkg::S_RESET: begin
				if (wr_i && (addr_i == `SPS_A_CTRL) && wdata_i[`SPS_CTRL_START] && start_ok) begin
					n.st = sps_pkg::S_DELAY;
					n.elapsed = '0;
					n.rep = '0;
					n.cur = rp.start - 9'h001;
					// start target applies from step one only
					n.first = (rp.start == 9'h001);
					n.pset = 4'h0;
				end
			end
			sps_pkg::S_DELAY: begin
				if (q.elapsed >= dly_u) begin
					n.st = sps_pkg::S_RUN;
					n.elapsed = '0;
				end else if (tk.min_tick) begin
					n.elapsed = q.elapsed + 13'h0001;
				end
			end
			sps_pkg::S_RUN: begin
				if (q.flt2 && (q.err_act == sps_pkg::E_RESET)) begin
					n.st = sps_pkg::S_RESET;
				end else if (q.flt2 && (q.err_act != sps_pkg::E_RUN)) begin
					n.st = sps_pkg::S_HOLD;
				end else begin
					if (q.elapsed >= dur_u) begin
						adv_step = 1'b1;
					end else if (adv_ev && !q.advm) begin
						adv_step = 1'b1;
					end else if (adv_ev && (adv_u != 13'h0000)) begin
						// jump never passes the step end
						n.elapsed = ((14'(q.elapsed) + 14'(adv_u)) > 14'(dur_u)) ? dur_u : q.elapsed + adv_u;
					end else if (tk.unit_tick) begin
						n.elapsed = q.elapsed + 13'h0001;
					end
				end
			end
			sps_pkg::S_HOLD: begin
				// held until fault clears or reset
				if (!q.flt2) begin
					n.st = sps_pkg::S_RUN;
				end
			end
			sps_pkg::S_FIXED: begin
			end
			default: begin
				n.st = sps_pkg::S_RESET;
			end
		endcase

		if (adv_step) begin
			n.elapsed = '0;
			n.first = 1'b0;
			if ((q.cur + 9'h001) < rp.nsteps) begin
				n.cur = q.cur + 9'h001;
			end else if ((q.rep + 14'h0001) < rp.reps) begin
				// repeat count read live each pass
				n.rep = q.rep + 14'h0001;
				n.cur = '0;
			end else if (q.endfix && !q.extfix) begin
				n.st = sps_pkg::S_FIXED;
			end else begin
				n.st = sps_pkg::S_RESET;
			end
		end

		if (exec) begin
			// zero keeps previous set; none yet gives one
			if (cs.pset != 4'h0) begin
				n.pset = cs.pset;
			end else if (q.pset == 4'h0) begin
				n.pset = 4'h1;
			end
			raw_sv = q.first ? rp.ssv : cs.sv;
			// clip to limits and flag it
			n.clip = (raw_sv > q.lim_hi) || (raw_sv < q.lim_lo);
			if (raw_sv > q.lim_hi) begin
				n.tgt = q.lim_hi;
			end else if (raw_sv < q.lim_lo) begin
				n.tgt = q.lim_lo;
			end else begin
				n.tgt = raw_sv;
			end
		end else begin
			raw_sv = q.tgt;
		end

		if (wr_i && (addr_i == `SPS_A_CTRL) && wdata_i[`SPS_CTRL_RESET]) begin
			n.st = sps_pkg::S_RESET;
		end

		if (pwr_ev) begin
			n.at = 1'b0;
			// default recovery discards the program; fixed always kept
			if (!q.recov && (q.st != sps_pkg::S_FIXED)) begin
				n.st = sps_pkg::S_RESET;
			end
		end

		out_v = (exec && q.flt2) ? q.err_out : computed_out_i;
		// on-off output is all or nothing
		if (q.onoff) begin
			out_v = (out_v >= `SPS_PCT_HALF) ? `SPS_PCT_FULL : 10'h000;
		end
		n.out = out_v;
		// blink while delaying; steady while running
		n.lamp = (n.st == sps_pkg::S_DELAY) ? tk.blink
			: ((n.st == sps_pkg::S_RUN) || (n.st == sps_pkg::S_HOLD));
	end

	// ****************************************
	// state and tables
	// ****************************************
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
			q.st <= sps_pkg::S_RESET;
			q.err_act <= sps_pkg::E_HOLD;
			q.ch1cnt <= `SPS_CH1_RST;
			q.lim_lo <= 16'h8000;
			q.lim_hi <= 16'h7FFF;
		end else begin
			q <= n;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i || reinit) begin
			for (int i = 0; i < `SPS_NPAT; i++) begin
				pat_mem[i] <= '{nsteps: 9'(i == 0), start: 9'(i == 0), reps: 14'h0001, ssv: 16'h0000};
			end
			for (int i = 0; i < `SPS_NSTEP_MAX; i++) begin
				step_mem[i] <= '{sv: 16'h0000, thi: 7'h00, tlo: `SPS_DUR_LO_RST, pset: 4'h0};
			end
		end else begin
			if (pat_we) begin
				pat_mem[q.psel] <= pat_wd;
			end
			if (step_we) begin
				step_mem[q.ssel] <= step_wd;
			end
		end
	end

	assign rdata_o        = q.rdata;
	assign run_lamp_o     = q.lamp;
	assign target_value_o = q.tgt;
	assign pset_o         = q.pset;
	assign ctrl_out_o     = q.out;
	assign clipped_o      = q.clip;
	assign fixed_o        = (q.st == sps_pkg::S_FIXED);
	assign auto_tuning_o  = q.at;
endmodule
`default_nettype wire

// ---- sps_regs.svh ----
// register offsets, fields, reset values and timing counts of the sequencer
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH

// ****************************************
// timing
// ****************************************
`define SPS_CLK_NS        20
`define SPS_SEC_NS        1000000000
`define SPS_SEC_CYC       (`SPS_SEC_NS / `SPS_CLK_NS)

// ****************************************
// register byte addresses
// ****************************************
`define SPS_A_CTRL        8'h00
`define SPS_A_CFG         8'h04
`define SPS_A_DELAY       8'h08
`define SPS_A_ADVT        8'h0C
`define SPS_A_ERROUT      8'h10
`define SPS_A_LIMIT       8'h14
`define SPS_A_CH1CNT      8'h18
`define SPS_A_PSEL        8'h1C
`define SPS_A_PDATA       8'h20
`define SPS_A_PSV         8'h24
`define SPS_A_SSEL        8'h28
`define SPS_A_SSV         8'h2C
`define SPS_A_STIME       8'h30
`define SPS_A_RUN         8'h34

// ****************************************
// fields
// ****************************************
`define SPS_CTRL_START    0
`define SPS_CTRL_RESET    1
`define SPS_CTRL_AT       2
`define SPS_CFG_UNIT      0
`define SPS_CFG_ERR       2:1
`define SPS_CFG_RECOV     3
`define SPS_CFG_ADVM      4
`define SPS_CFG_ENDFIX    5
`define SPS_CFG_EXTFIX    6
`define SPS_CFG_ONOFF     7
`define SPS_CFG_PAT       12:8
`define SPS_T_HI          6:0
`define SPS_T_LO          13:8
`define SPS_T_PSET        19:16
`define SPS_P_NSTEP       8:0
`define SPS_P_START       17:9
`define SPS_P_REPS        31:18

// ****************************************
// limits and reset values
// ****************************************
`define SPS_HI_MAX        7'h63
`define SPS_LO_MAX        6'h3B
`define SPS_MIN_PER_HR    13'h03C
`define SPS_NPAT          20
`define SPS_NPAT_W        5'h14
`define SPS_STEPS_PER_PAT 9'h014
`define SPS_NSTEP_MAX     400
`define SPS_PSET_MAX      4'hA
`define SPS_CH1_RST       5'h0A
`define SPS_REP_MAX       14'h270F
`define SPS_DUR_LO_RST    6'h01
`define SPS_PCT_HALF      10'h1F4
`define SPS_PCT_FULL      10'h3E8

`endif

// ---- sps_pkg.sv ----
// types of the setpoint program sequencer
package sps_pkg;

	typedef enum logic [4:0] {
		S_RESET = 5'h01,
		S_DELAY = 5'h02,
		S_RUN   = 5'h04,
		S_HOLD  = 5'h08,
		S_FIXED = 5'h10
	} sps_st_t;

	typedef enum logic [1:0] {
		E_HOLD  = 2'h0,
		E_RUN   = 2'h1,
		E_RESET = 2'h2
	} sps_err_t;

	typedef struct packed {
		logic signed [15:0] sv;
		logic [6:0]         thi;
		logic [5:0]         tlo;
		logic [3:0]         pset;
	} sps_step_t;

	typedef struct packed {
		logic [8:0]         nsteps;
		logic [8:0]         start;
		logic [13:0]        reps;
		logic signed [15:0] ssv;
	} sps_pat_t;

	typedef struct packed {
		sps_st_t            st;
		logic               unit_ms;
		sps_err_t           err_act;
		logic               recov;
		logic               advm;
		logic               endfix;
		logic               extfix;
		logic               onoff;
		logic [4:0]         pat;
		logic [6:0]         dly_hi;
		logic [5:0]         dly_lo;
		logic [6:0]         adv_hi;
		logic [5:0]         adv_lo;
		logic [9:0]         err_out;
		logic signed [15:0] lim_lo;
		logic signed [15:0] lim_hi;
		logic [4:0]         ch1cnt;
		logic [4:0]         psel;
		logic [8:0]         ssel;
		logic [8:0]         cur;
		logic [13:0]        rep;
		logic [12:0]        elapsed;
		logic               first;
		logic               at;
		logic signed [15:0] tgt;
		logic [3:0]         pset;
		logic [9:0]         out;
		logic               clip;
		logic               lamp;
		logic [31:0]        rdata;
		logic               flt1;
		logic               flt2;
		logic               adv1;
		logic               adv2;
		logic               adv3;
		logic               pwr1;
		logic               pwr2;
		logic               pwr3;
	} sps_state_t;

	typedef struct packed {
		logic [25:0] cyc;
		logic [5:0]  sec;
		logic        sec_tick;
		logic        min_tick;
		logic        blink;
	} sps_tb_t;

endpackage

// ---- sps_tick_if.sv ----
// time base signals between the sequencer and its time base
`timescale 1ns/1ps
`default_nettype none
interface sps_tick_if;
	logic unit_ms;
	logic sec_tick;
	logic min_tick;
	logic unit_tick;
	logic blink;
	modport src (input unit_ms, output sec_tick, output min_tick, output unit_tick, output blink);
	modport snk (output unit_ms, input sec_tick, input min_tick, input unit_tick, input blink);
endinterface
`default_nettype wire

// ---- sps_timebase.sv ----
// second and minute time base with blink phase
`timescale 1ns/1ps
`default_nettype none
`include "sps_regs.svh"
module sps_timebase #(
	parameter int unsigned SEC_CYCLES = `SPS_SEC_CYC
) (
	input  wire logic mclk_i,
	input  wire logic rst_i,
	sps_tick_if.src   tk
);
	sps_pkg::sps_tb_t q;
	sps_pkg::sps_tb_t n;

	always_comb begin
		n = q;
		n.sec_tick = 1'b0;
		n.min_tick = 1'b0;
		if (q.cyc >= 26'(SEC_CYCLES - 1)) begin
			n.cyc = '0;
			n.sec_tick = 1'b1;
			if (q.sec == `SPS_LO_MAX) begin
				n.sec = '0;
				n.min_tick = 1'b1;
			end else begin
				n.sec = q.sec + 6'h01;
			end
		end else begin
			n.cyc = q.cyc + 26'h0000001;
		end
		// lamp blinks at one hertz, half on
		n.blink = (n.cyc < 26'(SEC_CYCLES / 2));
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign tk.sec_tick  = q.sec_tick;
	assign tk.min_tick  = q.min_tick;
	assign tk.blink     = q.blink;
	assign tk.unit_tick = tk.unit_ms ? q.sec_tick : q.min_tick;
endmodule
`default_nettype wire

// ---- sps_operator_model.sv ----
// operator pins model: fault level, advance and power-return contacts
`timescale 1ns/1ps
`default_nettype none
module sps_operator_model (
	input  wire logic       mclk_i,
	input  wire logic       fault_req_i,
	input  wire logic       adv_req_i,
	input  wire logic       pwr_req_i,
	input  wire logic [9:0] out_val_i,
	output logic            fault_o,
	output logic            advance_o,
	output logic            power_up_o,
	output logic      [9:0] computed_out_o
);
	logic [2:0] adv_cnt;
	logic [2:0] pwr_cnt;

	initial begin
		fault_o = 1'h0;
		advance_o = 1'h0;
		power_up_o = 1'h0;
		adv_cnt = 3'h0;
		pwr_cnt = 3'h0;
		computed_out_o = 10'h000;
	end

	// contact held four clocks for the pin sync
	always @(posedge mclk_i) begin
		fault_o <= fault_req_i;
		computed_out_o <= out_val_i;
		adv_cnt <= adv_req_i ? 3'h4 : adv_cnt - {2'h0, adv_cnt != 3'h0};
		pwr_cnt <= pwr_req_i ? 3'h4 : pwr_cnt - {2'h0, pwr_cnt != 3'h0};
		advance_o <= adv_cnt != 3'h0;
		power_up_o <= pwr_cnt != 3'h0;
	end
endmodule
`default_nettype wire

// ---- sps_seq_properties.sv ----
// port checks of the sequencer
`timescale 1ns/1ps
`default_nettype none
module sps_seq_checker (
	input wire logic               mclk_i,
	input wire logic               rst_i,
	input wire logic [7:0]         addr_i,
	input wire logic [31:0]        wdata_i,
	input wire logic               wr_i,
	input wire logic               rd_i,
	input wire logic [31:0]        rdata_o,
	input wire logic               fault_i,
	input wire logic               advance_i,
	input wire logic               power_up_i,
	input wire logic [9:0]         computed_out_i,
	input wire logic               run_lamp_o,
	input wire logic signed [15:0] target_value_o,
	input wire logic [3:0]         pset_o,
	input wire logic [9:0]         ctrl_out_o,
	input wire logic               clipped_o,
	input wire logic               fixed_o,
	input wire logic               auto_tuning_o
);
	logic        recov_q;
	logic        onoff_q;
	logic [31:0] lim_q;

	// config mirror
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			recov_q <= 1'h0;
			onoff_q <= 1'h0;
			lim_q <= 32'h7FFF8000;
		end else if (wr_i && addr_i == 8'h04) begin
			recov_q <= wdata_i[3];
			onoff_q <= wdata_i[7];
		end else if (wr_i && addr_i == 8'h14) begin
			lim_q <= wdata_i;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	AST_RDATA_IDLE: assert property (!rd_i |=> rdata_o == 32'h0)
		else $error("idle rdata");
	AST_RDATA_UNMAP: assert property (rd_i && addr_i == 8'hFC |=> rdata_o == 32'h0)
		else $error("unmapped rdata");
	AST_PSET_RANGE: assert property (pset_o <= 4'hA)
		else $error("pset over 10");
	AST_RESET_CMD: assert property (wr_i && addr_i == 8'h00 && wdata_i[1] |-> ##2 (!fixed_o && !run_lamp_o))
		else $error("reset ignored");
	AST_AT_PWR: assert property ($rose(power_up_i) |-> ##[3:6] !auto_tuning_o)
		else $error("tuning kept");
	AST_PWR_RESET: assert property ($rose(power_up_i) && !recov_q && !fixed_o |-> ##[3:6] !run_lamp_o)
		else $error("program kept");
	AST_CLIP: assert property (clipped_o && lim_q == $past(lim_q, 2) |-> target_value_o == lim_q[15:0] || target_value_o == lim_q[31:16])
		else $error("clip off limit");
	AST_NOFAULT_OUT: assert property ((!fault_i && !onoff_q) [*5] |-> ctrl_out_o == $past(computed_out_i))
		else $error("output not computed");

	cover property (fixed_o);
	cover property (clipped_o);
	cover property ($rose(run_lamp_o));
endmodule

bind sps_sequencer sps_seq_checker sps_seq_checker_i (.*);
`default_nettype wire

// ---- sps_sequencer_tb.sv ----
// self-checking bench of the sequencer
`timescale 1ns/1ps
`default_nettype none
module sps_sequencer_tb;
	typedef struct {
		bit          wr;
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] e;
	} sps_row_t;

	logic               mclk_i = 1'h0;
	logic               rst_i = 1'h1;
	logic [7:0]         addr = 8'h00;
	logic [31:0]        wdata = 32'h0;
	logic               wr = 1'h0;
	logic               rd = 1'h0;
	logic               flt_req = 1'h0;
	logic               adv_req = 1'h0;
	logic               pwr_req = 1'h0;
	logic [31:0]        rdata;
	logic               fault;
	logic               adv;
	logic               pwr;
	logic [9:0]         comp;
	logic               lamp;
	logic signed [15:0] tgt;
	logic [3:0]         pset;
	logic [9:0]         cout;
	logic               clip;
	logic               fixd;
	logic               at;
	logic [31:0]        v;
	int                 n_errors = 0;
	int                 n_tests = 0;
	int                 n1;

	sps_row_t rows [23] = '{
		'{1'h0, 8'h04, 32'h0, 32'h0}, '{1'h0, 8'h08, 32'h0, 32'h0},
		'{1'h0, 8'h18, 32'h0, 32'h0A}, '{1'h0, 8'h30, 32'h0, 32'h100},
		'{1'h0, 8'h20, 32'h0, 32'h40201}, '{1'h1, 8'h04, 32'h1, 32'h1},
		'{1'h1, 8'h08, 32'h3F7F, 32'h3B63}, '{1'h1, 8'h0C, 32'h3F7F, 32'h3B63},
		'{1'h1, 8'h18, 32'h15, 32'h0A}, '{1'h1, 8'h18, 32'h14, 32'h14},
		'{1'h1, 8'h20, 32'h40390, 32'h40390}, '{1'h1, 8'h20, 32'h40391, 32'h40390},
		'{1'h1, 8'h20, 32'h40601, 32'h40201}, '{1'h1, 8'h20, 32'h40202, 32'h40202},
		'{1'h1, 8'h30, 32'h3F7F, 32'h3B63}, '{1'h1, 8'h30, 32'h900, 32'h900},
		'{1'h1, 8'h28, 32'h1, 32'h1}, '{1'h1, 8'h30, 32'hA0900, 32'hA0900},
		'{1'h1, 8'h30, 32'hB0900, 32'hA0900}, '{1'h1, 8'h30, 32'h900, 32'h900},
		'{1'h1, 8'h14, 32'h0064FF9C, 32'h0064FF9C}, '{1'h1, 8'h24, 32'h300, 32'h300},
		'{1'h1, 8'hFC, 32'h5, 32'h0}
	};
	// cfg, err value, fault st, cleared st, fault out
	logic [11:0] ft [5][5] = '{'{12'h01, 12'h123, 12'h08, 12'h04, 12'h123},
		'{12'h03, 12'h123, 12'h04, 12'h04, 12'h123}, '{12'h05, 12'h123, 12'h01, 12'h01, 12'h222},
		'{12'h81, 12'h1F4, 12'h08, 12'h04, 12'h3E8}, '{12'h81, 12'h1F3, 12'h08, 12'h04, 12'h0}};
	logic [13:0] avt [3][3] = '{'{14'h01, 14'h0, 14'h1}, '{14'h11, 14'h0, 14'h0},
		'{14'h11, 14'hA00, 14'h1}};
	logic [6:0] ed [4][2] = '{'{7'h21, 7'h10}, '{7'h61, 7'h01}, '{7'h01, 7'h01}, '{7'h09, 7'h04}};

	sps_sequencer #(.SEC_CYCLES(10)) sps_sequencer_i (
		.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .fault_i(fault), .advance_i(adv), .power_up_i(pwr),
		.computed_out_i(comp), .run_lamp_o(lamp), .target_value_o(tgt), .pset_o(pset),
		.ctrl_out_o(cout), .clipped_o(clip), .fixed_o(fixd), .auto_tuning_o(at)
	);
	sps_operator_model sps_operator_model_i (
		.mclk_i(mclk_i), .fault_req_i(flt_req), .adv_req_i(adv_req), .pwr_req_i(pwr_req),
		.out_val_i(10'h222), .fault_o(fault), .advance_o(adv), .power_up_o(pwr),
		.computed_out_o(comp)
	);

	always #10 mclk_i = ~mclk_i;

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			n_errors++;
		end
	endtask
	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		wr <= 1'h1;
		addr <= a;
		wdata <= d;
		@(posedge mclk_i);
		wr <= 1'h0;
	endtask
	task automatic rdr(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk_i);
		rd <= 1'h1;
		addr <= a;
		@(posedge mclk_i);
		rd <= 1'h0;
		@(negedge mclk_i);
		d = rdata;
	endtask
	task automatic wait_st(input logic [4:0] s);
		v = 32'h0;
		for (int i = 0; i < 2000 && v[4:0] !== s; i++)
			rdr(8'h00, v);
		chk("state", s, v[4:0]);
	endtask
	task automatic pgm(input bit stop);
		wrr(8'h00, stop ? 32'h2 : 32'h1);
		wait_st(stop ? 5'h01 : 5'h04);
	endtask
	task automatic do_reset;
		@(posedge mclk_i);
		rst_i <= 1'h1;
		repeat (20) @(posedge mclk_i);
		rst_i <= 1'h0;
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ****************************************
	// watchdog
	// ****************************************
	initial begin
		repeat (20000) @(posedge mclk_i);
		$display("MISMATCH watchdog expected end seen hang");
		n_errors++;
		finish_test();
	end

	// ****************************************
	// tests
	// ****************************************
	initial begin
		do_reset();
		foreach (rows[k]) begin
			if (rows[k].wr)
				wrr(rows[k].a, rows[k].d);
			rdr(rows[k].a, v);
			chk($sformatf("reg %h", rows[k].a), rows[k].e, v);
		end
		$display("registers done");
		wrr(8'h08, 32'h100);
		wrr(8'h00, 32'h1);
		rdr(8'h00, v);
		chk("delay state", 32'h02, v[4:0]);
		n1 = 0;
		repeat (40) @(negedge mclk_i) n1 += (lamp === 1'h1);
		chk("lamp blinks", 32'h1, n1 > 0 && n1 < 40);
		wait_st(5'h04);
		chk("lamp steady", 32'h1, lamp);
		chk("start target", 32'h0064, tgt);
		chk("clip flag", 32'h1, clip);
		chk("start set", 32'h1, pset);
		wrr(8'h04, 32'h0);
		rdr(8'h04, v);
		chk("unit kept", 32'h1, v);
		wrr(8'h20, 32'h40203);
		rdr(8'h20, v);
		chk("steps kept", 32'h40202, v);
		repeat (120) @(posedge mclk_i);
		rdr(8'h34, v);
		chk("next step", 32'h1, v[17:9]);
		chk("reused set", 32'h1, pset);
		wait_st(5'h01);
		$display("run done");
		wrr(8'h08, 32'h0);
		for (int k = 0; k < 5; k++) begin
			wrr(8'h04, ft[k][0]);
			wrr(8'h10, ft[k][1]);
			pgm(0);
			flt_req <= 1'h1;
			repeat (6) @(posedge mclk_i);
			rdr(8'h00, v);
			chk("fault state", ft[k][2], v[4:0]);
			chk("fault out", ft[k][4], cout);
			flt_req <= 1'h0;
			repeat (5) @(posedge mclk_i);
			rdr(8'h00, v);
			chk("cleared state", ft[k][3], v[4:0]);
			pgm(1);
		end
		$display("faults done");
		for (int k = 0; k < 3; k++) begin
			wrr(8'h04, avt[k][0]);
			wrr(8'h0C, avt[k][1]);
			pgm(0);
			adv_req <= 1'h1;
			@(posedge mclk_i);
			adv_req <= 1'h0;
			repeat (8) @(posedge mclk_i);
			rdr(8'h34, v);
			chk("advanced step", avt[k][2], v[17:9]);
			rdr(8'h00, v);
			chk("advance state", 32'h04, v[4:0]);
			pgm(1);
		end
		$display("advance done");
		for (int k = 0; k < 2; k++) begin
			wrr(8'h04, ed[k][0]);
			pgm(0);
			wait_st(ed[k][1]);
			chk("fixed", ed[k][1] == 7'h10, fixd);
			pgm(1);
		end
		$display("end done");
		for (int k = 2; k < 4; k++) begin
			wrr(8'h04, ed[k][0]);
			pgm(0);
			wrr(8'h00, 32'h4);
			@(negedge mclk_i);
			chk("tuning on", 32'h1, at);
			pwr_req <= 1'h1;
			@(posedge mclk_i);
			pwr_req <= 1'h0;
			repeat (8) @(posedge mclk_i);
			rdr(8'h00, v);
			chk("power state", ed[k][1], v[4:0]);
			chk("tuning off", 32'h0, at);
			pgm(1);
		end
		$display("power done");
		pgm(0);
		do_reset();
		rdr(8'h00, v);
		chk("reset state", 32'h01, v[4:0]);
		chk("reset lamp", 32'h0, lamp);
		rdr(8'h18, v);
		chk("reset count", 32'h0A, v);
		$display("reset done");
		finish_test();
	end
endmodule
`default_nettype wire
